// ===== hdl/vlb_line_buffer.sv
// 910 x 8 line buffer with independent write and read ports
// port clocks arrive as ordinary inputs synchronous to sys_clk_i and are edge detected
// Notes on behaviour
// - 910 words of 8 bits, separate buses
// - write and read ports run independently
// - write clear, enabled, loads address 0
// - write clear, disabled, loads address 909
// - read clear, enabled, loads address 0
// - read clear, disabled, loads address 909
// - enabled write cycle stores input word
// - disabled write stores nothing, holds address
// - disabled read floats outputs, holds address
// - controls sampled opening edge, data closing edge
// - write address advances per enabled cycle
// - write address wraps 909 to 0
// - read controls sampled, read starts, same edge
// - read address advances per enabled cycle
// - read address wraps 909 to 0
// - delay 10 to 910 words by clear offset
`timescale 1ns/10ps
module vlb_line_buffer (
  // system
  input  wire logic                          sys_clk_i,
  input  wire logic                          nrst_i,
  // write port
  input  wire logic                          wr_clk_i,
  input  wire logic                          wr_addr_clear_n_i,
  input  wire logic                          wr_enable_n_i,
  input  wire logic [vlb_pkg::DATA_W-1:0]    wr_data_in_i,
  // read port
  input  wire logic                          rd_clk_i,
  input  wire logic                          rd_addr_clear_n_i,
  input  wire logic                          rd_enable_n_i,
  output logic      [vlb_pkg::DATA_W-1:0]    rd_data_out_o,
  output logic                               rd_data_oe_o,
  // counter observation
  output logic      [vlb_pkg::ADDR_W-1:0]    wr_addr_o,
  output logic      [vlb_pkg::ADDR_W-1:0]    rd_addr_o
);

  logic                        wr_clk_q;
  logic                        rd_clk_q;
  logic                        wr_edge;
  logic                        rd_edge;
  logic [vlb_pkg::ADDR_W-1:0]  wr_addr_q;
  logic [vlb_pkg::ADDR_W-1:0]  rd_addr_q;
  logic [vlb_pkg::ADDR_W-1:0]  wr_cyc_addr;
  logic [vlb_pkg::ADDR_W-1:0]  rd_cyc_addr;
  logic [vlb_pkg::ADDR_W-1:0]  wr_addr_d;
  logic [vlb_pkg::ADDR_W-1:0]  rd_addr_d;
  logic                        wr_pend_q;
  logic [vlb_pkg::ADDR_W-1:0]  wr_pend_addr_q;
  logic                        mem_wr_en;
  logic                        mem_rd_en;

  // port clock edges; the port clocks are only sampled, so each must stay
  // high and low for at least one system clock period
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_clk_q <= 1'b0;
      rd_clk_q <= 1'b0;
    end
    else
    begin
      wr_clk_q <= wr_clk_i;
      rd_clk_q <= rd_clk_i;
    end
  end

  assign wr_edge = wr_clk_i & ~wr_clk_q;
  assign rd_edge = rd_clk_i & ~rd_clk_q;

  assign wr_cyc_addr = !wr_addr_clear_n_i
                     ? (wr_enable_n_i ? vlb_pkg::ADDR_LAST : vlb_pkg::ADDR_FIRST)
                     : wr_addr_q;

  assign rd_cyc_addr = !rd_addr_clear_n_i
                     ? (rd_enable_n_i ? vlb_pkg::ADDR_LAST : vlb_pkg::ADDR_FIRST)
                     : rd_addr_q;

  always_comb
  begin
    wr_addr_d = wr_cyc_addr;
    if (!wr_enable_n_i)
    begin
      if (wr_cyc_addr == vlb_pkg::ADDR_LAST)
      begin
        wr_addr_d = vlb_pkg::ADDR_FIRST;
      end
      else
      begin
        wr_addr_d = wr_cyc_addr + 10'h001;
      end
    end
  end

  always_comb
  begin
    rd_addr_d = rd_cyc_addr;
    if (!rd_enable_n_i)
    begin
      if (rd_cyc_addr == vlb_pkg::ADDR_LAST)
      begin
        rd_addr_d = vlb_pkg::ADDR_FIRST;
      end
      else
      begin
        rd_addr_d = rd_cyc_addr + 10'h001;
      end
    end
  end

  // delay set by clear offset; counters move only on their own port edge
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_addr_q <= vlb_pkg::ADDR_RST;
    end
    else if (wr_edge)
    begin
      wr_addr_q <= wr_addr_d;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rd_addr_q <= vlb_pkg::ADDR_RST;
    end
    else if (rd_edge)
    begin
      rd_addr_q <= rd_addr_d;
    end
  end

  // enable taken at the opening edge, data stored at the closing edge
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_q      <= 1'b0;
      wr_pend_addr_q <= vlb_pkg::ADDR_RST;
    end
    else if (wr_edge)
    begin
      wr_pend_q      <= ~wr_enable_n_i;
      wr_pend_addr_q <= wr_cyc_addr;
    end
  end

  // store only for an enabled cycle
  assign mem_wr_en = wr_edge & wr_pend_q;

  // read launched by the opening edge
  assign mem_rd_en = rd_edge & ~rd_enable_n_i;

  vlb_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (mem_wr_en),
    .wr_addr_i (wr_pend_addr_q),
    .wr_data_i (wr_data_in_i),
    .rd_en_i   (mem_rd_en),
    .rd_addr_i (rd_cyc_addr),
    .rd_data_o (rd_data_out_o)
  );

  // outputs released while reading is disabled
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rd_data_oe_o <= 1'b0;
    end
    else if (rd_edge)
    begin
      rd_data_oe_o <= ~rd_enable_n_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_addr_o <= vlb_pkg::ADDR_RST;
      rd_addr_o <= vlb_pkg::ADDR_RST;
    end
    else
    begin
      // show the counter itself, not the next value, so a port held enabled
      // between edges does not read one ahead of the stored address
      wr_addr_o <= wr_edge ? wr_addr_d : wr_addr_q;
      rd_addr_o <= rd_edge ? rd_addr_d : rd_addr_q;
    end
  end

endmodule : vlb_line_buffer

// ===== hdl/vlb_pkg.sv
// constants shared by the 910 x 8 video line buffer and its storage array
// assumes nothing beyond a single system clock domain
package vlb_pkg;

  localparam int unsigned DEPTH      = 910;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 10;

  // address loaded by a clear with the port enabled, and with it disabled
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_LAST  = 10'h38d;

  // value of the address counters after system reset
  localparam logic [ADDR_W-1:0] ADDR_RST   = 10'h000;

  // shortest and longest delay-line length, in words
  localparam int unsigned DELAY_MIN_WORDS = 10;
  localparam int unsigned DELAY_MAX_WORDS = 910;

endpackage : vlb_pkg

// ===== hdl/vlb_mem.sv
// storage array for the line buffer: one write port, one registered read port
// assumes both ports are driven from the same system clock
`timescale 1ns/10ps
module vlb_mem (
  // clock
  input  wire logic                          sys_clk_i,
  // write port
  input  wire logic                          wr_en_i,
  input  wire logic [vlb_pkg::ADDR_W-1:0]    wr_addr_i,
  input  wire logic [vlb_pkg::DATA_W-1:0]    wr_data_i,
  // read port
  input  wire logic                          rd_en_i,
  input  wire logic [vlb_pkg::ADDR_W-1:0]    rd_addr_i,
  output logic      [vlb_pkg::DATA_W-1:0]    rd_data_o
);

  logic [vlb_pkg::DATA_W-1:0] store_q [vlb_pkg::DEPTH];

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
    begin
      store_q[wr_addr_i] <= wr_data_i;
    end
  end

  // read data held between reads so a disabled read keeps the last word
  always_ff @(posedge sys_clk_i)
  begin
    if (rd_en_i)
    begin
      rd_data_o <= store_q[rd_addr_i];
    end
  end

endmodule : vlb_mem

// ===== verification/vlb_line_buffer_chk.sv
// checker on the line buffer ports: counter loads, steps, wrap, read float
// assumes port clocks are oversampled by sys_clk_i as the design does
`timescale 1ns/10ps
module vlb_line_buffer_chk (
  // all ports of the line buffer
  input wire logic       sys_clk_i, nrst_i, wr_clk_i, wr_addr_clear_n_i,
  input wire logic       wr_enable_n_i, rd_clk_i, rd_addr_clear_n_i, rd_enable_n_i,
  input wire logic [7:0] wr_data_in_i, rd_data_out_o,
  input wire logic       rd_data_oe_o,
  input wire logic [9:0] wr_addr_o, rd_addr_o
);
  localparam logic [9:0] L = vlb_pkg::ADDR_LAST;
  logic w_q, r_q, we, re;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge sys_clk_i)
  begin
    w_q <= wr_clk_i;
    r_q <= rd_clk_i;
  end
  assign we = wr_clk_i & ~w_q;
  assign re = rd_clk_i & ~r_q;
  wclr_en_a: assert property (
    we && !wr_addr_clear_n_i && !wr_enable_n_i |=> wr_addr_o == 10'h001) else $error("wclr0");
  wclr_dis_a: assert property (
    we && !wr_addr_clear_n_i && wr_enable_n_i |=> wr_addr_o == L) else $error("wclr909");
  rclr_en_a: assert property (
    re && !rd_addr_clear_n_i && !rd_enable_n_i |=> rd_addr_o == 10'h001) else $error("rclr0");
  rclr_dis_a: assert property (
    re && !rd_addr_clear_n_i && rd_enable_n_i |=> rd_addr_o == L) else $error("rclr909");
  wr_hold_a: assert property (
    we && wr_addr_clear_n_i && wr_enable_n_i |=> $stable(wr_addr_o)) else $error("whold");
  wr_step_a: assert property (
    we && wr_addr_clear_n_i && !wr_enable_n_i |=>
    wr_addr_o == ($past(wr_addr_o) == L ? 10'h000 : $past(wr_addr_o) + 10'h001))
    else $error("wstep");
  rd_step_a: assert property (
    re && rd_addr_clear_n_i && !rd_enable_n_i |=>
    rd_addr_o == ($past(rd_addr_o) == L ? 10'h000 : $past(rd_addr_o) + 10'h001))
    else $error("rstep");
  rd_off_a: assert property (
    re && rd_addr_clear_n_i && rd_enable_n_i |=> !rd_data_oe_o && $stable(rd_addr_o))
    else $error("roff");
endmodule : vlb_line_buffer_chk
bind vlb_line_buffer vlb_line_buffer_chk u_chk (.sys_clk_i, .nrst_i, .wr_clk_i,
  .wr_addr_clear_n_i, .wr_enable_n_i, .wr_data_in_i, .rd_clk_i, .rd_addr_clear_n_i,
  .rd_enable_n_i, .rd_data_out_o, .rd_data_oe_o, .wr_addr_o, .rd_addr_o);

// ===== verification/vlb_ctl_model.sv
// controller model: one port cycle per call, clock high one cycle, low one
// assumes the caller waits for each call to return before the next
`timescale 1ns/10ps
module vlb_ctl_model (
  input  wire logic sys_clk_i,
  output logic      wck_o = 1'b0, wclr_o = 1'b1, wen_o = 1'b1,
  output logic [7:0] wd_o = 8'h00,
  output logic      rck_o = 1'b0, rclr_o = 1'b1, ren_o = 1'b1
);
  // short cycles keep a line well inside its limit
  task automatic wcyc(input logic c, input logic e, input logic [7:0] d);
    @(posedge sys_clk_i);
    {wck_o, wclr_o, wen_o, wd_o} <= {1'b1, c, e, d};
    @(posedge sys_clk_i);
    wck_o <= 1'b0;
  endtask : wcyc
  task automatic rcyc(input logic c, input logic e);
    @(posedge sys_clk_i);
    {rck_o, rclr_o, ren_o} <= {1'b1, c, e};
    @(posedge sys_clk_i);
    rck_o <= 1'b0;
  endtask : rcyc
endmodule : vlb_ctl_model

// ===== verification/vlb_line_buffer_bench.sv
// bench: fill, read back, clear to 909 and wrap on both ports
// assumes the controller model spaces port edges two cycles apart
`timescale 1ns/10ps
module vlb_line_buffer_bench;
  logic       sys_clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       wr_clk, wclr, wen, rck, rclr, ren, oe;
  logic [7:0] wd, rd;
  logic [9:0] wa, ra;
  int         err_count = 0;
  int         tests_run = 0;
  int         cyc = 0;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  vlb_ctl_model u_ctl (.sys_clk_i, .wck_o(wr_clk), .wclr_o(wclr), .wen_o(wen), .wd_o(wd),
    .rck_o(rck), .rclr_o(rclr), .ren_o(ren));
  vlb_line_buffer u_dut (.sys_clk_i, .nrst_i, .wr_clk_i(wr_clk), .wr_addr_clear_n_i(wclr),
    .wr_enable_n_i(wen), .wr_data_in_i(wd), .rd_clk_i(rck), .rd_addr_clear_n_i(rclr),
    .rd_enable_n_i(ren), .rd_data_out_o(rd), .rd_data_oe_o(oe), .wr_addr_o(wa),
    .rd_addr_o(ra));
  task automatic close_out;
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // read one cycle, then look at word and enable once settled
  task automatic rchk(input logic c, input logic e, input logic [7:0] x);
    u_ctl.rcyc(c, e);
    #1;
    chk({2'b00, rd}, {2'b00, x});
    chk({9'h000, oe}, {9'h000, ~e});
  endtask : rchk
  task automatic t_fill;
    u_ctl.wcyc(1'b0, 1'b0, 8'h00);
    u_ctl.wcyc(1'b1, 1'b0, 8'ha5);
    u_ctl.wcyc(1'b1, 1'b0, 8'h3c);
    u_ctl.wcyc(1'b1, 1'b1, 8'h81);
    #1;
    chk(wa, 10'h003);
    rchk(1'b0, 1'b0, 8'ha5);
    rchk(1'b1, 1'b0, 8'h3c);
    rchk(1'b1, 1'b0, 8'h81);
    rchk(1'b1, 1'b1, 8'h81);
    chk(ra, 10'h003);
  endtask : t_fill
  task automatic t_wrap;
    fork
      u_ctl.wcyc(1'b0, 1'b1, 8'h00);
      u_ctl.rcyc(1'b0, 1'b1);
    join
    #1;
    chk(wa, vlb_pkg::ADDR_LAST);
    chk(ra, vlb_pkg::ADDR_LAST);
    u_ctl.wcyc(1'b1, 1'b0, 8'h00);
    u_ctl.wcyc(1'b1, 1'b0, 8'h5a);
    u_ctl.wcyc(1'b1, 1'b1, 8'hc3);
    rchk(1'b1, 1'b0, 8'h5a);
    rchk(1'b1, 1'b0, 8'hc3);
    chk(ra, 10'h001);
  endtask : t_wrap
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_fill();
    t_wrap();
    close_out();
  end
endmodule : vlb_line_buffer_bench
